//--- verilog/usb_endpoint_command_engine.sv
// Overview of operation
// - Command f4h then a read returns the per-endpoint interrupt flags.
// - Each packet received or sent sets its endpoint flag and raises the interrupt.
// - Bus reset raises the interrupt with all endpoint flags cleared.
// - Reading the interrupt register clears the pending bus reset; endpoint flags stay set.
// - Command 00h+index selects endpoint, rewinds pointer; read gives full in bit 0.
// - Command 40h+index read returns last status, clears flag and status.
// - Status carries the four-bit error code from the serial engine, forced to zero on success.
// - Status bit reads 1 when data moved without error.
// - Setup bit marks a SETUP packet; always 0 for IN buffers.
// - Status holds the DATA1 bit and an overrun bit for unread status.
// - Write after 40h+index stalls on bit 0 set, unstalls on clear.
// - A SETUP token unstalls a stalled control endpoint.
// - Unstalling by a status write flushes the buffer and resets the toggle to DATA0.
// - Command f0h reads up to ten buffer bytes, pointer advancing per read.
// - Buffer commands never rewind the pointer; only selection does.
// - Image is two header bytes then eight data bytes; byte 0 bit 7 is success.
// - SETUP flushes the IN buffer and blocks clear and validate on control endpoints.
// - Command f1h unblocks clear and validate after a SETUP.
// - A new SETUP overwrites the buffer, blocks again; blocked clears are ignored.
// - A received OUT packet sets full; command f2h clears it.
// - Command fah sets full on the selected IN buffer.
// - Command f5h reads the eleven-bit frame number, low byte first.
// - Completion signal is true whenever a new action may start.
// - Interrupt output is the OR of all endpoint flags and the pending bus reset.
`timescale 1ns/1ps
module usb_endpoint_command_engine
  import usb_cmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             cmd_action_done,
  output logic             endpoint_irq_out,
  input  wire logic        se_pkt_valid,
  input  wire logic [2:0]  se_pkt_ep,
  input  wire logic        se_pkt_ok,
  input  wire logic [3:0]  se_pkt_err,
  input  wire logic        se_pkt_setup,
  input  wire logic        se_pkt_data1,
  input  wire logic [9:0]  se_pkt_len,
  input  wire logic        se_bus_reset,
  input  wire logic        se_sof_ok,
  input  wire logic [10:0] se_frame,
  input  wire logic        se_buf_wr,
  input  wire logic [2:0]  se_buf_ep,
  input  wire logic [3:0]  se_buf_idx,
  input  wire logic [7:0]  se_buf_data,
  input  wire logic [2:0]  se_rd_ep,
  input  wire logic [3:0]  se_rd_idx,
  output logic      [7:0]  se_rd_data,
  output logic      [5:0]  ep_full_out,
  output logic      [5:0]  ep_stall_out,
  output logic      [5:0]  ep_toggle_out
);
  import usb_cmd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]           cmd;
    logic [2:0]           sel;
    logic [3:0]           ptr;
    logic                 frame_hi;
    logic [5:0]           flags;
    logic                 rst_pend;
    logic                 lock;
    logic [5:0]           full;
    logic [5:0]           stall;
    logic [5:0]           tog;
    logic [5:0][7:0]      stat;
    logic [5:0]           sval;
    logic [10:0]          frame;
    logic [5:0][9:0][7:0] buff;
    logic [7:0]           rdata;
    logic [7:0]           se_rdata;
    logic                 done;
    logic                 irq;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [2:0] cmd_ep;
  logic       cmd_wr;
  logic       dat_wr;
  logic       dat_rd;
  logic       cmd_is_sel;
  logic       cmd_is_stat;

  assign cmd_ep      = state_r.cmd[2:0];
  assign cmd_wr      = bus_wr && (bus_addr == ADDR_CMD);
  assign dat_wr      = bus_wr && (bus_addr == ADDR_DATA);
  assign dat_rd      = bus_rd && (bus_addr == ADDR_DATA);
  assign cmd_is_sel  = (state_r.cmd[7:3] == CMD_SEL_HI) && (cmd_ep <= EP_LAST);
  assign cmd_is_stat = (state_r.cmd[7:3] == CMD_STAT_HI) && (cmd_ep <= EP_LAST);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       blocked;
    logic [7:0] st;
    state_nxt       = state_r;
    blocked         = 1'b0;
    st              = 8'h00;
    state_nxt.rdata = 8'h00;
    state_nxt.done  = 1'b1;

    // Every action finishes in the cycle it is strobed, so done never drops.
    if (cmd_wr) begin
      state_nxt.cmd = bus_wdata;
      if (bus_wdata[7:3] == CMD_SEL_HI && bus_wdata[2:0] <= EP_LAST) begin
        state_nxt.sel = bus_wdata[2:0];
        state_nxt.ptr = 4'h0;
      end
      blocked = state_r.lock && (state_r.sel <= EP_CTL_IN);
      unique case (bus_wdata)
        CMD_ACK:   state_nxt.lock = 1'b0;
        CMD_CLR: begin
          if (!blocked) begin
            state_nxt.full[state_r.sel] = 1'b0;
          end
        end
        CMD_VAL: begin
          if (!blocked) begin
            state_nxt.full[state_r.sel] = 1'b1;
          end
        end
        CMD_FRAME: state_nxt.frame_hi = 1'b0;
        default:   ;
      endcase
    end

    if (dat_rd) begin
      if (state_r.cmd == CMD_IRQ) begin
        state_nxt.rdata    = {2'h0, state_r.flags};
        state_nxt.rst_pend = 1'b0;
      end else if (state_r.cmd == CMD_BUF) begin
        if (state_r.ptr < PTR_END) begin
          state_nxt.rdata = state_r.buff[state_r.sel][state_r.ptr];
          state_nxt.ptr   = state_r.ptr + 4'h1;
        end
      end else if (state_r.cmd == CMD_FRAME) begin
        state_nxt.rdata    = state_r.frame_hi ? {5'h00, state_r.frame[10:8]}
                                              : state_r.frame[7:0];
        state_nxt.frame_hi = 1'b1;
      end else if (cmd_is_sel) begin
        state_nxt.rdata = {7'h00, state_r.full[cmd_ep]};
      end else if (cmd_is_stat) begin
        state_nxt.rdata         = state_r.stat[cmd_ep];
        state_nxt.flags[cmd_ep] = 1'b0;
        state_nxt.sval[cmd_ep]  = 1'b0;
        state_nxt.stat[cmd_ep]  = 8'h00;
      end
    end

    if (dat_wr) begin
      if (state_r.cmd == CMD_BUF) begin
        if (state_r.ptr < PTR_END) begin
          state_nxt.buff[state_r.sel][state_r.ptr] = bus_wdata;
          state_nxt.ptr = state_r.ptr + 4'h1;
        end
      end else if (cmd_is_stat) begin
        if (bus_wdata[0]) begin
          state_nxt.stall[cmd_ep] = 1'b1;
        end else if (state_r.stall[cmd_ep]) begin
          state_nxt.stall[cmd_ep] = 1'b0;
          state_nxt.full[cmd_ep]  = 1'b0;
          state_nxt.tog[cmd_ep]   = 1'b0;
        end
      end
    end

    // Engine events come last so that they beat bus actions in the same cycle.
    if (se_buf_wr && se_buf_ep <= EP_LAST && se_buf_idx < PTR_END) begin
      state_nxt.buff[se_buf_ep][se_buf_idx] = se_buf_data;
    end

    if (se_pkt_valid && se_pkt_ep <= EP_LAST) begin
      st                  = 8'h00;
      st[ST_OK]           = se_pkt_ok;
      st[ST_ERR_LO +: 4]  = se_pkt_ok ? ERR_NONE : se_pkt_err;
      st[ST_SETUP]        = se_pkt_setup && !se_pkt_ep[0];
      st[ST_DATA1]        = se_pkt_data1;
      st[ST_OVR]          = state_r.sval[se_pkt_ep];
      state_nxt.stat[se_pkt_ep]  = st;
      state_nxt.sval[se_pkt_ep]  = 1'b1;
      state_nxt.flags[se_pkt_ep] = 1'b1;
      if (se_pkt_ok) begin
        if (!se_pkt_ep[0]) begin
          state_nxt.full[se_pkt_ep] = 1'b1;
          state_nxt.buff[se_pkt_ep][IDX_HDR0] = {1'b1, 5'h00, se_pkt_len[9:8]};
          state_nxt.buff[se_pkt_ep][IDX_HDR1] = se_pkt_len[7:0];
          state_nxt.tog[se_pkt_ep] = !se_pkt_data1;
        end else begin
          state_nxt.full[se_pkt_ep] = 1'b0;
          state_nxt.tog[se_pkt_ep]  = !state_r.tog[se_pkt_ep];
        end
      end
      if (se_pkt_setup && se_pkt_ep == EP_CTL_OUT) begin
        state_nxt.lock             = 1'b1;
        state_nxt.full[EP_CTL_IN]  = 1'b0;
        state_nxt.stall[EP_CTL_OUT] = 1'b0;
        state_nxt.stall[EP_CTL_IN]  = 1'b0;
      end
    end

    if (se_bus_reset) begin
      state_nxt.flags    = 6'h00;
      state_nxt.rst_pend = 1'b1;
    end

    if (se_sof_ok) begin
      state_nxt.frame = se_frame;
    end

    state_nxt.se_rdata = 8'h00;
    if (se_rd_ep <= EP_LAST && se_rd_idx < PTR_END) begin
      state_nxt.se_rdata = state_r.buff[se_rd_ep][se_rd_idx];
    end

    state_nxt.irq = (|state_nxt.flags) || state_nxt.rst_pend;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus_rdata        = state_r.rdata;
  assign cmd_action_done  = state_r.done;
  assign endpoint_irq_out = state_r.irq;
  assign se_rd_data       = state_r.se_rdata;
  assign ep_full_out      = state_r.full;
  assign ep_stall_out     = state_r.stall;
  assign ep_toggle_out    = state_r.tog;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cmd(logic [7:0] c);
    cmd_wr && bus_wdata == c;
  endsequence

  sequence s_read_of(logic [7:0] c);
    dat_rd && state_r.cmd == c;
  endsequence

  sequence s_pkt;
    se_pkt_valid && se_pkt_ep <= EP_LAST;
  endsequence

  property p_irq_read;
    s_read_of(CMD_IRQ) |=> bus_rdata == {2'h0, $past(state_r.flags)};
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("irq register read wrong");

  property p_pkt_flag;
    se_pkt_valid && se_pkt_ep <= EP_LAST && !se_bus_reset |=> endpoint_irq_out;
  endproperty
  a_pkt_flag: assert property (p_pkt_flag) else $error("packet did not raise irq");

  property p_bus_reset;
    se_bus_reset |=> state_r.flags == 6'h00 && state_r.rst_pend && endpoint_irq_out;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset irq missing");

  property p_irq_clear;
    s_read_of(CMD_IRQ) ##0 (!se_bus_reset && state_r.flags == 6'h00 && !se_pkt_valid)
      |=> !endpoint_irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared by read");

  property p_select;
    cmd_wr && bus_wdata[7:3] == CMD_SEL_HI && bus_wdata[2:0] <= EP_LAST
      |=> state_r.ptr == 4'h0 && state_r.sel == $past(bus_wdata[2:0]);
  endproperty
  a_select: assert property (p_select) else $error("select did not rewind pointer");

  property p_stat_clear;
    dat_rd && cmd_is_stat && !se_pkt_valid |=> !state_r.flags[cmd_ep] && !state_r.sval[cmd_ep];
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read left flag");

  property p_stall;
    dat_wr && cmd_is_stat && bus_wdata[0] && !se_pkt_valid |=> ep_stall_out[$past(cmd_ep)];
  endproperty
  a_stall: assert property (p_stall) else $error("endpoint not stalled");

  property p_ptr_inc;
    (dat_rd || dat_wr) && state_r.cmd == CMD_BUF && state_r.ptr < PTR_END && !cmd_wr
      |=> state_r.ptr == $past(state_r.ptr) + 4'h1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("buffer pointer did not advance");

  property p_setup_lock;
    se_pkt_valid && se_pkt_setup && se_pkt_ep == EP_CTL_OUT
      |=> state_r.lock && !state_r.full[EP_CTL_IN] ##1 !ep_full_out[EP_CTL_IN];
  endproperty
  a_setup_lock: assert property (p_setup_lock) else $error("setup did not lock");

  property p_clear_blocked;
    s_cmd(CMD_CLR) ##0 (state_r.lock && state_r.sel <= EP_CTL_IN && !se_pkt_valid)
      |=> state_r.full == $past(state_r.full);
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("blocked clear acted");

  property p_validate;
    s_cmd(CMD_VAL) ##0 (!(state_r.lock && state_r.sel <= EP_CTL_IN) && !se_pkt_valid)
      |=> ep_full_out[$past(state_r.sel)];
  endproperty
  a_validate: assert property (p_validate) else $error("validate did not set full");

  property p_frame_lo;
    s_read_of(CMD_FRAME) && !state_r.frame_hi |=> bus_rdata == $past(state_r.frame[7:0]);
  endproperty
  a_frame_lo: assert property (p_frame_lo) else $error("frame low byte wrong");

  property p_sel_read;
    dat_rd && cmd_is_sel |=> bus_rdata == {7'h00, $past(state_r.full[cmd_ep])};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read wrong");

  property p_stat_read;
    dat_rd && cmd_is_stat |=> bus_rdata == $past(state_r.stat[cmd_ep]);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_err_code;
    s_pkt ##0 !se_pkt_ok
      |=> state_r.stat[$past(se_pkt_ep)][ST_ERR_LO +: 4] == $past(se_pkt_err);
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code wrong");

  property p_status_ok;
    s_pkt |=> state_r.stat[$past(se_pkt_ep)][ST_OK] == $past(se_pkt_ok);
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("success bit wrong");

  property p_setup_in;
    s_pkt ##0 se_pkt_ep[0] |=> !state_r.stat[$past(se_pkt_ep)][ST_SETUP];
  endproperty
  a_setup_in: assert property (p_setup_in) else $error("setup bit set on IN");

  property p_status_bits;
    s_pkt |=> state_r.stat[$past(se_pkt_ep)][ST_DATA1] == $past(se_pkt_data1)
      && state_r.stat[$past(se_pkt_ep)][ST_OVR] == $past(state_r.sval[se_pkt_ep]);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("toggle or overrun wrong");

  property p_setup_unstall;
    s_pkt ##0 (se_pkt_setup && se_pkt_ep == EP_CTL_OUT)
      |=> !ep_stall_out[EP_CTL_OUT] && !ep_stall_out[EP_CTL_IN];
  endproperty
  a_setup_unstall: assert property (p_setup_unstall) else $error("setup left stall");

  property p_unstall;
    dat_wr && cmd_is_stat && !bus_wdata[0] && state_r.stall[cmd_ep] && !se_pkt_valid
      |=> !ep_stall_out[$past(cmd_ep)] && !ep_full_out[$past(cmd_ep)]
      && !ep_toggle_out[$past(cmd_ep)];
  endproperty
  a_unstall: assert property (p_unstall) else $error("unstall did not flush");

  property p_out_full;
    s_pkt ##0 (se_pkt_ok && !se_pkt_ep[0]) |=> ep_full_out[$past(se_pkt_ep)];
  endproperty
  a_out_full: assert property (p_out_full) else $error("OUT packet left buffer empty");

  property p_done;
    !rst |=> cmd_action_done;
  endproperty
  a_done: assert property (p_done) else $error("done dropped");

endmodule

//--- verilog/usb_cmd_pkg.sv
package usb_cmd_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_EP    = 6;
  localparam int unsigned BUF_BYTES = 10;
  localparam logic [2:0]  EP_LAST   = 3'h5;
  localparam logic [3:0]  PTR_END   = 4'ha;
  localparam logic [2:0]  EP_CTL_OUT = 3'h0;
  localparam logic [2:0]  EP_CTL_IN  = 3'h1;

  // ****************************************************************
  // Bus qualifier and command codes
  // ****************************************************************
  localparam logic       ADDR_CMD  = 1'b1;
  localparam logic       ADDR_DATA = 1'b0;
  localparam logic [4:0] CMD_SEL_HI  = 5'h00;
  localparam logic [4:0] CMD_STAT_HI = 5'h08;
  localparam logic [7:0] CMD_BUF   = 8'hf0;
  localparam logic [7:0] CMD_ACK   = 8'hf1;
  localparam logic [7:0] CMD_CLR   = 8'hf2;
  localparam logic [7:0] CMD_IRQ   = 8'hf4;
  localparam logic [7:0] CMD_FRAME = 8'hf5;
  localparam logic [7:0] CMD_VAL   = 8'hfa;

  // ****************************************************************
  // Status byte and buffer image layout
  // ****************************************************************
  localparam int unsigned ST_OK     = 0;
  localparam int unsigned ST_ERR_LO = 1;
  localparam int unsigned ST_SETUP  = 5;
  localparam int unsigned ST_DATA1  = 6;
  localparam int unsigned ST_OVR    = 7;
  localparam logic [3:0]  ERR_NONE  = 4'h0;
  localparam int unsigned B0_OK     = 7;
  localparam logic [3:0]  IDX_HDR0  = 4'h0;
  localparam logic [3:0]  IDX_HDR1  = 4'h1;

endpackage

//--- test/usb_engine_model.sv
`timescale 1ns/1ps
module usb_engine_model (
  input  wire logic        clk,
  output logic             se_pkt_valid,
  output logic [2:0]       se_pkt_ep,
  output logic             se_pkt_ok,
  output logic [3:0]       se_pkt_err,
  output logic             se_pkt_setup,
  output logic             se_pkt_data1,
  output logic [9:0]       se_pkt_len,
  output logic             se_bus_reset,
  output logic             se_sof_ok,
  output logic [10:0]      se_frame,
  output logic             se_buf_wr,
  output logic [2:0]       se_buf_ep,
  output logic [3:0]       se_buf_idx,
  output logic [7:0]       se_buf_data,
  output logic [2:0]       se_rd_ep,
  output logic [3:0]       se_rd_idx
);
  // ****************************************************************
  // Serial engine side
  // ****************************************************************
  // Fields are inverted once a pulse ends, so the device cannot lean on stale values.
  initial begin
    {se_pkt_valid, se_pkt_ep, se_pkt_ok, se_pkt_err, se_pkt_setup, se_pkt_data1} = '0;
    {se_pkt_len, se_bus_reset, se_sof_ok, se_frame, se_buf_wr, se_buf_ep} = '0;
    {se_buf_idx, se_buf_data, se_rd_ep, se_rd_idx} = '0;
  end

  task automatic pkt(input logic [2:0] ep, input logic ok, input logic [3:0] err,
                     input logic su, input logic d1);
    @(posedge clk);
    se_pkt_valid <= 1'b1;
    {se_pkt_ep, se_pkt_ok, se_pkt_err, se_pkt_setup, se_pkt_data1} <= {ep, ok, err, su, d1};
    se_pkt_len <= 10'h8;
    @(posedge clk);
    se_pkt_valid <= 1'b0;
    {se_pkt_ep, se_pkt_ok, se_pkt_err, se_pkt_setup, se_pkt_data1} <= ~{ep, ok, err, su, d1};
    se_pkt_len <= ~10'h8;
  endtask

  task automatic bufw(input logic [2:0] ep, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    {se_buf_wr, se_buf_ep, se_buf_idx, se_buf_data} <= {1'b1, ep, idx, d};
    @(posedge clk);
    {se_buf_wr, se_buf_ep, se_buf_idx, se_buf_data} <= {1'b0, ~ep, ~idx, ~d};
  endtask

  task automatic sof(input logic [10:0] f);
    @(posedge clk);
    {se_sof_ok, se_frame} <= {1'b1, f};
    @(posedge clk);
    {se_sof_ok, se_frame} <= {1'b0, ~f};
  endtask

  task automatic busrst();
    @(posedge clk);
    se_bus_reset <= 1'b1;
    @(posedge clk);
    se_bus_reset <= 1'b0;
  endtask

  task automatic rdaddr(input logic [2:0] ep, input logic [3:0] idx);
    @(posedge clk);
    {se_rd_ep, se_rd_idx} <= {ep, idx};
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
  import usb_cmd_pkg::*;
  logic        clk, rst, bus_addr, bus_wr, bus_rd, cmd_action_done, endpoint_irq_out;
  logic [7:0]  bus_wdata, bus_rdata, se_rd_data, d, w_data;
  logic        se_pkt_valid, se_pkt_ok, se_pkt_setup, se_pkt_data1, se_bus_reset;
  logic        se_sof_ok, se_buf_wr;
  logic [2:0]  se_pkt_ep, se_buf_ep, se_rd_ep;
  logic [3:0]  se_pkt_err, se_buf_idx, se_rd_idx;
  logic [9:0]  se_pkt_len;
  logic [10:0] se_frame;
  logic [5:0]  ep_full_out, ep_stall_out, ep_toggle_out, flags;
  logic [7:0]  st [6];
  logic [7:0]  w [10];
  logic [7:0]  q [$];
  int          bad_count, check_count, seed;

  usb_endpoint_command_engine DUT (.clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .cmd_action_done, .endpoint_irq_out, .se_pkt_valid, .se_pkt_ep, .se_pkt_ok,
    .se_pkt_err, .se_pkt_setup, .se_pkt_data1, .se_pkt_len, .se_bus_reset, .se_sof_ok,
    .se_frame, .se_buf_wr, .se_buf_ep, .se_buf_idx, .se_buf_data(w_data), .se_rd_ep,
    .se_rd_idx, .se_rd_data, .ep_full_out, .ep_stall_out, .ep_toggle_out);
  usb_engine_model eng (.clk, .se_pkt_valid, .se_pkt_ep, .se_pkt_ok, .se_pkt_err,
    .se_pkt_setup, .se_pkt_data1, .se_pkt_len, .se_bus_reset, .se_sof_ok, .se_frame,
    .se_buf_wr, .se_buf_ep, .se_buf_idx, .se_buf_data(w_data), .se_rd_ep, .se_rd_idx);

  // ****************************************************************
  // Bus tasks and reference model
  // ****************************************************************
  task automatic bw(input logic a, input logic [7:0] v);
    @(posedge clk);
    `CHK(cmd_action_done, 1'b1)
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] c);
    bw(ADDR_CMD, c);
  endtask

  task automatic rdchk(input logic [7:0] e);
    @(posedge clk);
    bus_addr <= ADDR_DATA;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
  endtask

  // Outputs lag an event by one edge; three are waited so the check never races them.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic ev(input logic [2:0] ep, input logic ok, input logic [3:0] err,
                    input logic su, input logic d1);
    eng.pkt(ep, ok, err, su, d1);
    st[ep] = {flags[ep], d1, su & ~ep[0], ok ? 4'h0 : err, ok};
    flags[ep] = 1'b1;
    settle();
  endtask

  task automatic stat(input logic [2:0] ep);
    cmd({CMD_STAT_HI, ep});
    rdchk(st[ep]);
    flags[ep] = 1'b0;
    st[ep] = 8'h00;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 20000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'h87b0;
    {bus_addr, bus_wr, bus_rd, bus_wdata, flags} = '0;
    foreach (st[i]) st[i] = 8'h00;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(cmd_action_done, 1'b1)
    eng.busrst();
    settle();
    `CHK(endpoint_irq_out, 1'b1)
    cmd(CMD_IRQ);
    rdchk(8'h00);
    settle();
    `CHK(endpoint_irq_out, 1'b0)
    q = {8'h80, 8'h08};
    for (int i = 2; i < 10; i++) begin
      d = 8'($random(seed));
      q.push_back(d);
      eng.bufw(3'h2, i[3:0], d);
    end
    ev(3'h2, 1'b1, 4'h0, 1'b0, 1'b1);
    `CHK(endpoint_irq_out, 1'b1)
    `CHK(ep_full_out[2], 1'b1)
    cmd(CMD_IRQ);
    rdchk({2'b00, flags});
    cmd({CMD_SEL_HI, 3'h2});
    rdchk(8'h01);
    cmd(CMD_BUF);
    for (int i = 0; i < 10; i++) begin
      if (i == 4) begin
        cmd(CMD_FRAME);
        cmd(CMD_BUF);
      end
      rdchk(q.pop_front());
    end
    rdchk(8'h00);
    stat(3'h2);
    settle();
    `CHK(endpoint_irq_out, 1'b0)
    cmd(CMD_CLR);
    settle();
    `CHK(ep_full_out[2], 1'b0)
    ev(3'h4, 1'b1, 4'h0, 1'b0, 1'b0);
    for (int e = 1; e < 16; e++) begin
      ev(3'h4, 1'b0, e[3:0], 1'b0, e[0]);
      stat(3'h4);
    end
    cmd(8'h03);
    cmd(CMD_VAL);
    ev(3'h3, 1'b1, 4'h0, 1'b1, 1'b0);
    stat(3'h3);
    `CHK(ep_toggle_out[3], 1'b1)
    cmd(CMD_VAL);
    cmd(8'h43);
    bw(ADDR_DATA, 8'hff);
    settle();
    `CHK({ep_stall_out[3], ep_full_out[3]}, 2'b11)
    cmd(8'h43);
    bw(ADDR_DATA, 8'hfe);
    settle();
    `CHK({ep_stall_out[3], ep_full_out[3], ep_toggle_out[3]}, 3'b000)
    cmd(8'h05);
    cmd(CMD_BUF);
    for (int i = 0; i < 10; i++) begin
      w[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'h08 : 8'($random(seed));
      bw(ADDR_DATA, w[i]);
    end
    cmd(8'h05);
    cmd(CMD_BUF);
    for (int i = 0; i < 10; i++) rdchk(w[i]);
    eng.rdaddr(3'h5, 4'h2);
    settle();
    `CHK(se_rd_data, w[2])
    cmd(8'h40);
    bw(ADDR_DATA, 8'h01);
    ev(3'h0, 1'b1, 4'h0, 1'b1, 1'b0);
    `CHK(ep_stall_out[0], 1'b0)
    cmd(8'h01);
    cmd(CMD_VAL);
    settle();
    `CHK(ep_full_out[1], 1'b0)
    cmd(CMD_ACK);
    cmd(CMD_VAL);
    settle();
    `CHK(ep_full_out[1], 1'b1)
    ev(3'h0, 1'b1, 4'h0, 1'b1, 1'b1);
    `CHK(ep_full_out[1], 1'b0)
    cmd(8'h00);
    cmd(CMD_CLR);
    settle();
    `CHK(ep_full_out[0], 1'b1)
    stat(3'h0);
    cmd(CMD_ACK);
    cmd(CMD_CLR);
    settle();
    `CHK(ep_full_out[0], 1'b0)
    d = 8'($random(seed));
    eng.sof({d[2:0], 8'h5a ^ d});
    settle();
    cmd(CMD_FRAME);
    rdchk(8'h5a ^ d);
    rdchk({5'h00, d[2:0]});
    cmd(CMD_IRQ);
    rdchk({2'b00, flags});
    settle();
    `CHK(endpoint_irq_out, |flags)
    report_and_stop();
  end
endmodule
